// file: logic/qmc_ctrl.sv
// Quad mode entry and exit controller of a serial flash command interface.
// Assumes a host that drives sck_i and cs_n_i, much slower than clk_i, and an
// Avalon-MM master for the register window.
//
// What this block does
// - Opcode 05h returns status register one.
// - Opcode 35h returns status register two.
// - Write status 01h second byte bit sets.
// - Second byte bit one zero clears quad enable.
// - Mode upper nibble A keeps continuous read.
// - Mode 00h exits after current read.
// - Eight clocks all-ones on lines exits mode.
// - Other upper nibble leaves continuous read.
// - Full quad bit is volatile.
// - Soft reset pair leaves full quad mode.
// - Reset needs 66h then 99h, any width.
//
// The Avalon-MM interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/10ps
module qmc_ctrl
  import qmc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic [3:0] quad_data_lines_i,
  output logic [3:0] quad_data_lines_o,
  output logic [3:0] quad_data_lines_oe_n_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and edge detection.

  qmc_pins_t pin_raw;
  qmc_pins_t pin;
  logic sck_d;
  logic cs_n_d;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;

  assign pin_raw = {sck_i, cs_n_i, quad_data_lines_i};

  qmc_sync #(.W(6), .RV(6'h1F)) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i(pin_raw),
    .q_o(pin)
  );

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sck_d <= 1'b0;
      cs_n_d <= 1'b1;
    end else begin
      sck_d <= pin.sck;
      cs_n_d <= pin.cs_n;
    end
  end

  assign sck_rise = pin.sck & ~sck_d & ~pin.cs_n;
  assign sck_fall = ~pin.sck & sck_d & ~pin.cs_n;
  assign cs_fall = ~pin.cs_n & cs_n_d;
  assign cs_rise = pin.cs_n & ~cs_n_d;

  ////////////////////////////////////////////////////////////////////////////
  // State and shared signals.

  qmc_state_t state;
  logic [7:0] op;
  logic [5:0] cnt;
  logic [23:0] shreg;
  logic [7:0] tx;
  logic wide;
  logic cfg_hit;
  logic [7:0] stat1_nv;
  logic wel;
  logic quad_enable_bit;
  logic [7:0] cfg;
  logic [7:0] pat;
  logic cont;
  logic cont_next;
  logic mode_seen;
  logic rst_en;
  logic [3:0] ones_cnt;
  logic byte_n;
  logic [7:0] first_byte;
  logic [23:0] next_shreg;
  logic [5:0] next_cnt;
  logic done;
  logic [7:0] byte_in;
  logic cmd_done;
  logic xfer_done;
  logic mode_done;
  logic soft_rst;
  logic ones_evt;
  logic out_dir;
  logic qpi;
  logic [7:0] stat1_v;
  logic [7:0] stat2_v;

  function automatic logic [5:0] step(input logic w);
    return w ? 6'h04 : 6'h01;
  endfunction

  function automatic logic [5:0] target(input qmc_state_t s);
    case (s)
      ST_CMD: return CMD_BITS;
      ST_ADDR: return ADDR_BITS;
      ST_MODE: return MODE_BITS;
      ST_DUMMY: return DUMMY_BITS;
      default: return BYTE_BITS;
    endcase
  endfunction

  assign qpi = cfg[QPI_BIT];
  assign stat1_v = {stat1_nv[7:2], wel, 1'b0};
  assign stat2_v = {6'h00, quad_enable_bit, 1'b0};
  assign out_dir = (op != OP_WR_STAT) && (op != OP_WR_CFG);

  always_comb begin
    if (wide) begin
      next_shreg = {shreg[19:0], pin.dq};
    end else begin
      next_shreg = {shreg[22:0], pin.dq[0]};
    end
    next_cnt = cnt + step(wide);
    done = sck_rise && (state != ST_IDLE) && (state != ST_SKIP) &&
           (next_cnt == target(state));
    byte_in = next_shreg[7:0];
  end

  assign cmd_done = done && (state == ST_CMD);
  assign xfer_done = done && (state == ST_XFER);
  assign mode_done = done && (state == ST_MODE);
  assign soft_rst = cmd_done && (byte_in == OP_RST) && rst_en;
  assign ones_evt = sck_rise && (pin.dq == ALL_ONES) &&
                    (ones_cnt == MODE_RESET_CLKS - 4'h1);

  // Byte presented on the lines for a read, chosen by instruction.
  function automatic logic [7:0] rd_val(input logic [7:0] o, input logic h);
    case (o)
      OP_RD_STAT1: return stat1_v;
      OP_RD_STAT2: return stat2_v;
      OP_RD_CFG: return h ? cfg : 8'h00;
      OP_QUAD_RD: return pat;
      default: return 8'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer.

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
      op <= 8'h00;
      cnt <= 6'h00;
      shreg <= 24'h000000;
      tx <= 8'h00;
      wide <= 1'b0;
      cfg_hit <= 1'b0;
    end else if (pin.cs_n) begin
      state <= ST_IDLE;
      cnt <= 6'h00;
    end else if (cs_fall) begin
      cnt <= 6'h00;
      if (cont) begin
        state <= ST_ADDR;
        op <= OP_QUAD_RD;
        wide <= 1'b1;
      end else begin
        state <= ST_CMD;
        wide <= qpi;
      end
    end else if (ones_evt) begin
      // The idle pattern must not start a data phase.
      state <= ST_SKIP;
    end else if (sck_rise && state != ST_SKIP) begin
      shreg <= next_shreg;
      cnt <= done ? 6'h00 : next_cnt;
      if (done) begin
        case (state)
          ST_CMD: begin
            op <= byte_in;
            case (byte_in)
              OP_RD_STAT1, OP_RD_STAT2: begin
                state <= ST_XFER;
                tx <= rd_val(byte_in, 1'b0);
              end
              OP_WR_STAT: state <= ST_XFER;
              OP_RD_CFG, OP_WR_CFG: state <= ST_ADDR;
              OP_QUAD_RD: begin
                // Quad transfers are refused while quad enable is clear.
                state <= quad_enable_bit ? ST_ADDR : ST_SKIP;
                wide <= 1'b1;
              end
              default: state <= ST_SKIP;
            endcase
          end
          ST_ADDR: begin
            cfg_hit <= next_shreg == CFG_ADDR;
            if (op == OP_QUAD_RD) begin
              state <= ST_MODE;
            end else begin
              state <= ST_XFER;
              tx <= rd_val(op, next_shreg == CFG_ADDR);
            end
          end
          ST_MODE: state <= ST_DUMMY;
          ST_DUMMY: begin
            state <= ST_XFER;
            tx <= pat;
          end
          ST_XFER: tx <= rd_val(op, cfg_hit);
          default: state <= ST_SKIP;
        endcase
      end
    end else if (sck_fall && state == ST_XFER && out_dir) begin
      tx <= wide ? {tx[3:0], 4'h0} : {tx[6:0], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output drive, changed on the falling serial clock edge.

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      quad_data_lines_o <= 4'h0;
      quad_data_lines_oe_n_o <= 4'hF;
    end else if (state != ST_XFER || !out_dir || pin.cs_n) begin
      quad_data_lines_oe_n_o <= 4'hF;
    end else if (sck_fall) begin
      if (wide) begin
        quad_data_lines_o <= tx[7:4];
        quad_data_lines_oe_n_o <= 4'h0;
      end else begin
        quad_data_lines_o <= {2'h0, tx[7], 1'b0};
        quad_data_lines_oe_n_o <= 4'hD;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status and configuration registers.

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      stat1_nv <= STAT1_RST;
      wel <= 1'b0;
      quad_enable_bit <= 1'b0;
      cfg <= CFG_RST;
      rst_en <= 1'b0;
      byte_n <= 1'b0;
      first_byte <= 8'h00;
    end else begin
      if (cs_fall) begin
        byte_n <= 1'b0;
      end
      if (cmd_done) begin
        rst_en <= byte_in == OP_RST_EN;
      end
      if (soft_rst) begin
        // Only the volatile settings, cfg and wel, fall back; the other status contents survive.
        cfg <= CFG_RST;
        wel <= 1'b0;
      end else if (cmd_done && byte_in == OP_WR_EN) begin
        wel <= 1'b1;
      end else if (xfer_done && op == OP_WR_STAT) begin
        byte_n <= 1'b1;
        if (!byte_n) begin
          first_byte <= byte_in;
        end else begin
          // The non-volatile bits 7 to 2 of status one need a prior write enable.
          if (wel) begin
            stat1_nv <= {first_byte[7:2], 2'h0};
          end
          quad_enable_bit <= byte_in[QUAD_EN_BIT];
          wel <= 1'b0;
        end
      end else if (xfer_done && op == OP_WR_CFG && cfg_hit) begin
        cfg <= byte_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Continuous read mode.

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ones_cnt <= 4'h0;
    end else if (cs_fall) begin
      ones_cnt <= 4'h0;
    end else if (sck_rise) begin
      if (pin.dq != ALL_ONES) begin
        ones_cnt <= ALL_ONES;
      end else if (ones_cnt < MODE_RESET_CLKS) begin
        ones_cnt <= ones_cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cont <= 1'b0;
      cont_next <= 1'b0;
      mode_seen <= 1'b0;
    end else if (soft_rst || ones_evt) begin
      cont <= 1'b0;
      cont_next <= 1'b0;
      mode_seen <= 1'b0;
    end else if (mode_done) begin
      // Upper nibble A enters or stays; anything else leaves at read end.
      cont_next <= quad_enable_bit && (byte_in[7:4] == CONT_NIBBLE);
      mode_seen <= 1'b1;
    end else if (cs_rise && mode_seen) begin
      cont <= cont_next;
      mode_seen <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave with one wait cycle per access.

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h00000000;
      pat <= PAT_RST;
    end else begin
      avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
      if (avs_read_i && avs_waitrequest_o) begin
        case (avs_address_i)
          REG_STAT1: avs_readdata_o <= {24'h000000, stat1_v};
          REG_STAT2: avs_readdata_o <= {24'h000000, stat2_v};
          REG_CFG: avs_readdata_o <= {24'h000000, cfg};
          REG_MODE: avs_readdata_o <= {24'h000000, 2'h0, qpi, cont, cont_next,
                                       rst_en, wel, quad_enable_bit};
          REG_PAT: avs_readdata_o <= {24'h000000, pat};
          default: avs_readdata_o <= 32'h00000000;
        endcase
      end
      if (avs_write_i && !avs_waitrequest_o && avs_address_i == REG_PAT &&
          avs_byteenable_i[0]) begin
        pat <= avs_writedata_i[7:0];
      end
    end
  end

endmodule

// file: common/qmc_pkg.sv
// Shared constants and types of the quad mode entry and exit controller.
// Assumes a host SPI controller on the pins and an Avalon-MM master on the bus.
package qmc_pkg;

  typedef struct packed {
    logic sck;
    logic cs_n;
    logic [3:0] dq;
  } qmc_pins_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_CMD   = 3'h1,
    ST_ADDR  = 3'h3,
    ST_MODE  = 3'h2,
    ST_DUMMY = 3'h6,
    ST_XFER  = 3'h7,
    ST_SKIP  = 3'h5
  } qmc_state_t;

  // Instruction codes.
  localparam logic [7:0] OP_RD_STAT1 = 8'h05;
  localparam logic [7:0] OP_RD_STAT2 = 8'h35;
  localparam logic [7:0] OP_WR_STAT = 8'h01;
  localparam logic [7:0] OP_WR_EN = 8'h06;
  localparam logic [7:0] OP_RD_CFG = 8'h65;
  localparam logic [7:0] OP_WR_CFG = 8'h71;
  localparam logic [7:0] OP_QUAD_RD = 8'hEB;
  localparam logic [7:0] OP_RST_EN = 8'h66;
  localparam logic [7:0] OP_RST = 8'h99;

  localparam logic [23:0] CFG_ADDR = 24'h800003;
  localparam logic [3:0] CONT_NIBBLE = 4'hA;
  localparam logic [3:0] ALL_ONES = 4'hF;
  localparam logic [3:0] MODE_RESET_CLKS = 4'h8;

  // Field positions.
  localparam int WIP_BIT = 0;
  localparam int WEL_BIT = 1;
  localparam int QUAD_EN_BIT = 1;
  localparam int QPI_BIT = 6;

  // Phase lengths in bits.
  localparam logic [5:0] CMD_BITS = 6'h08;
  localparam logic [5:0] ADDR_BITS = 6'h18;
  localparam logic [5:0] MODE_BITS = 6'h08;
  localparam logic [5:0] DUMMY_BITS = 6'h10;
  localparam logic [5:0] BYTE_BITS = 6'h08;

  // Reset values.
  localparam logic [7:0] STAT1_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] PAT_RST = 8'h00;

  // Register byte offsets.
  localparam logic [4:0] REG_STAT1 = 5'h00;
  localparam logic [4:0] REG_STAT2 = 5'h04;
  localparam logic [4:0] REG_CFG = 5'h08;
  localparam logic [4:0] REG_MODE = 5'h0C;
  localparam logic [4:0] REG_PAT = 5'h10;

endpackage

// file: logic/qmc_sync.sv
// Two-stage synchroniser for the pin inputs of the quad mode controller.
// Assumes every bit is asynchronous to clk_i; only the second stage is read.
`timescale 1ns/10ps
module qmc_sync #(
  parameter int W = 6,
  parameter logic [W-1:0] RV = '1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta <= RV;
      q_o <= RV;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule

// file: testbench/qmc_props.sv
// Port assertions for the quad mode controller.
// Assumes one clk_i domain with synchronous active-low reset.
`timescale 1ns/10ps
module qmc_props (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic [3:0] quad_data_lines_o,
  input wire logic [3:0] quad_data_lines_oe_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wait_pulse_a: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus answer not one cycle");
  wait_cause_a: assert property (
    !avs_waitrequest_o |-> $past(avs_read_i) || $past(avs_write_i))
    else $error("answer without request");
  rdata_hold_a: assert property (
    $changed(avs_readdata_o) |-> !avs_waitrequest_o && avs_read_i)
    else $error("read data moved outside a read");
  oe_release_a: assert property (
    $rose(cs_n_i) |-> ##[1:8] quad_data_lines_oe_n_o == 4'hF)
    else $error("lines not released after select");
  oe_idle_a: assert property (
    cs_n_i [*8] |-> quad_data_lines_oe_n_o == 4'hF)
    else $error("lines driven while deselected");
  oe_shape_a: assert property (
    quad_data_lines_oe_n_o inside {4'hF, 4'hD, 4'h0})
    else $error("odd enable pattern");
  dq_fall_a: assert property (
    $changed(quad_data_lines_o) |-> !sck_i)
    else $error("output changed with clock high");
  rst_vals_a: assert property (
    $rose(rst_n_i) |-> avs_waitrequest_o && avs_readdata_o == 32'h0
      && quad_data_lines_oe_n_o == 4'hF)
    else $error("state not cleared by reset");
endmodule
bind qmc_ctrl qmc_props u_props (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .sck_i(sck_i), .cs_n_i(cs_n_i),
  .quad_data_lines_o(quad_data_lines_o), .quad_data_lines_oe_n_o(quad_data_lines_oe_n_o));

// file: testbench/qmc_host.sv
// Host serial controller model, mode 0, one link clock per 25 block clocks.
// Assumes the bench calls its tasks right after a rising edge of clk_i.
`timescale 1ns/10ps
module qmc_host (
  input wire logic clk_i,
  input wire logic [3:0] dq_i,
  output logic sck_o,
  output logic cs_n_o,
  output logic [3:0] dq_o
);
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    dq_o = 4'h0;
  end
  task automatic beg();
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    repeat (12) @(posedge clk_i);
  endtask
  // Lines are toggled on release so a stale level is never mistaken for data.
  task automatic fin();
    repeat (4) @(posedge clk_i);
    cs_n_o <= 1'b1;
    dq_o <= ~dq_o;
    repeat (10) @(posedge clk_i);
  endtask
  task automatic sh(input logic [31:0] v, input int n, input int w, output logic [31:0] r);
    r = 32'h0;
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clk_i);
      dq_o <= (w == 4) ? v[i*4+:4] : {~dq_o[3:1], v[i]};
      repeat (12) @(posedge clk_i);
      sck_o <= 1'b1;
      r = (w == 4) ? {r[27:0], dq_i} : {r[30:0], dq_i[1]};
      repeat (12) @(posedge clk_i);
      sck_o <= 1'b0;
    end
  endtask
endmodule

// file: testbench/qmc_ctrl_test.sv
// Self-checking bench: register bus reads and host link frames.
// Assumes qmc_host on the link and qmc_props bound to the design.
`timescale 1ns/10ps
module qmc_ctrl_test;
  import qmc_pkg::*;
  logic clk_i, rst_n_i, avs_read_i, avs_write_i, avs_waitrequest_o, sck, cs_n, ct;
  logic [4:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, r;
  logic [3:0] dq_o, oe_n, dq_h;
  logic [3:0] be = 4'hF;
  logic [7:0] pat, s1, rx;
  logic [15:0] rq[$];
  logic [7:0] sq[$];
  logic [7:0] modes[6] = '{8'hA5, 8'hA3, 8'h00, 8'hA5, 8'h5A, 8'hA5};
  int error_cnt = 0, checked = 0, cyc = 0, seed = 32'hB60F, wq = 1;
  event rx_ev;
  wire [3:0] ln = (~oe_n & dq_o) | (oe_n & dq_h);
  qmc_ctrl uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(be), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .sck_i(sck), .cs_n_i(cs_n),
    .quad_data_lines_i(ln), .quad_data_lines_o(dq_o), .quad_data_lines_oe_n_o(oe_n));
  qmc_host h (.clk_i(clk_i), .dq_i(ln), .sck_o(sck), .cs_n_o(cs_n), .dq_o(dq_h));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////
  task automatic miss(input string m);
    error_cnt++;
    $display("MISMATCH %0t %s", $time, m);
  endtask
  task automatic chk_reg(input logic [31:0] g);
    logic [15:0] e;
    checked++;
    e = rq.size() ? rq.pop_front() : 16'h00FF;
    if ((g[7:0] & e[15:8]) !== e[7:0]) miss($sformatf("reg %h exp %h", g, e[7:0]));
  endtask
  task automatic chk_spi(input logic [7:0] g);
    logic [7:0] e;
    checked++;
    e = sq.size() ? sq.pop_front() : ~g;
    if (g !== e) miss($sformatf("link %h exp %h", g, e));
  endtask
  always @(posedge clk_i) if (avs_read_i && avs_waitrequest_o === 1'b0) chk_reg(avs_readdata_o);
  always @(rx_ev) chk_spi(rx);
  task automatic tally_and_finish();
    if (rq.size() || sq.size()) miss("result missing");
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      miss("timeout");
      tally_and_finish();
    end
  end
  // Waitrequest is sampled at the same edge the request is judged on.
  // Only the bench timeout ends the wait for an answer.
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_address_i <= a;
    avs_writedata_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
    rq.push_back({m, e});
    bus(1'b0, a, 8'h00);
  endtask
  task automatic by(input logic [7:0] v);
    h.sh({24'h0, v}, wq == 4 ? 2 : 8, wq, r);
  endtask
  task automatic rb(input logic [7:0] e, input int w);
    sq.push_back(e);
    h.sh($random(seed), w == 4 ? 2 : 8, w, r);
    rx = r[7:0];
    ->rx_ev;
  endtask
  task automatic adr();
    by(CFG_ADDR[23:16]);
    by(CFG_ADDR[15:8]);
    by(CFG_ADDR[7:0]);
  endtask
  task automatic op1(input logic [7:0] o);
    h.beg();
    by(o);
    h.fin();
  endtask
  task automatic stat(input logic [7:0] o, input logic [7:0] e);
    h.beg();
    by(o);
    rb(e, 1);
    h.fin();
  endtask
  task automatic wst(input logic [7:0] a, input logic [7:0] b, input bit two);
    h.beg();
    by(OP_WR_STAT);
    by(a);
    if (two) by(b);
    h.fin();
  endtask
  task automatic wcfg(input logic [7:0] d);
    h.beg();
    by(OP_WR_CFG);
    adr();
    by(d);
    h.fin();
    wq = d[QPI_BIT] ? 4 : 1;
  endtask
  task automatic rcfg(input logic [7:0] e);
    h.beg();
    by(OP_RD_CFG);
    adr();
    rb(e, wq);
    h.fin();
  endtask
  task automatic qr(input logic [7:0] m);
    h.beg();
    if (!ct) by(OP_QUAD_RD);
    h.sh(32'h0, 6, 4, r);
    h.sh({24'h0, m}, 2, 4, r);
    h.sh($random(seed), 4, 4, r);
    rb(pat, 4);
    h.fin();
    ct = m[7:4] == CONT_NIBBLE;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    rst_n_i = 1'b0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 5'h00;
    avs_writedata_i = 32'h0;
    ct = 1'b0;
    pat = 8'($random(seed));
    s1 = 8'($random(seed));
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    for (int i = 0; i < 6; i++) rd(5'(i * 4), 8'hFF, 8'h00);
    bus(1'b1, REG_PAT, pat);
    bus(1'b1, REG_STAT2, 8'hFF);
    bus(1'b1, 5'h14, 8'hFF);
    be <= 4'hE;
    bus(1'b1, REG_PAT, ~pat);
    be <= 4'hF;
    rd(REG_PAT, 8'hFF, pat);
    rd(REG_STAT2, 8'hFF, 8'h00);
    $display("registers done");
    op1(OP_WR_EN);
    rd(REG_STAT1, 8'h02, 8'h02);
    wst(s1, 8'h02, 1'b1);
    rd(REG_STAT2, 8'hFF, 8'h02);
    stat(OP_RD_STAT1, s1 & 8'hFC);
    stat(OP_RD_STAT2, 8'h02);
    wst(8'h00, 8'h00, 1'b0);
    rd(REG_STAT2, 8'hFF, 8'h02);
    wst(8'h00, 8'h00, 1'b1);
    stat(OP_RD_STAT2, 8'h00);
    stat(OP_RD_STAT1, s1 & 8'hFC);
    wst(8'h00, 8'h02, 1'b1);
    $display("status done");
    foreach (modes[i]) begin
      qr(modes[i]);
      rd(REG_MODE, 8'h3F, ct ? 8'h19 : 8'h01);
    end
    h.beg();
    h.sh(32'hFFFFFFFF, 8, 4, r);
    h.fin();
    ct = 1'b0;
    rd(REG_MODE, 8'h3F, 8'h01);
    qr(8'h00);
    $display("continuous done");
    rcfg(CFG_RST);
    wcfg(8'h40);
    rd(REG_CFG, 8'hFF, 8'h40);
    rd(REG_MODE, 8'h20, 8'h20);
    rcfg(8'h40);
    wcfg(8'h00);
    rd(REG_CFG, 8'hFF, 8'h00);
    wcfg(8'h40);
    op1(OP_RST);
    rd(REG_CFG, 8'hFF, 8'h40);
    op1(OP_RST_EN);
    rd(REG_MODE, 8'h04, 8'h04);
    op1(OP_RST);
    wq = 1;
    rd(REG_CFG, 8'hFF, 8'h00);
    wcfg(8'h40);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    wq = 1;
    @(posedge clk_i);
    rd(REG_CFG, 8'hFF, 8'h00);
    $display("full quad done");
    tally_and_finish();
  end
endmodule
